// >>> rtl/tcp_edge.sv
// Purpose: divide the sampled external clock by 8, flag falling edges
// Assumes: external oscillator already synchronous to i_clk
// Notes: o_fall is a one-cycle pulse per eighth external clock, o_ext_tick a one-cycle pulse per external clock
`timescale 1ns/100ps
module tcp_edge (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ext_osc,
   output logic o_fall,
   output logic o_ext_tick
);
   logic ext_q;
   logic [1:0] div_q;
   logic div_out_q;
   logic rise;

   assign rise = i_ext_osc & ~ext_q;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= i_ext_osc;
      end
   end

   // divide by 8: toggle the divided level every fourth external edge
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         div_q <= 2'h0;
         div_out_q <= 1'b0;
      end else if (rise) begin
         div_q <= div_q + 2'h1;
         if (div_q == tcp_pkg::DIV8_LAST) begin
            div_out_q <= ~div_out_q;
         end
      end
   end

   assign o_fall = rise && (div_q == tcp_pkg::DIV8_LAST) && div_out_q;
   assign o_ext_tick = rise;

   fall_once_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_fall |=> !o_fall) else $error("capture pulse longer than one cycle");
endmodule

// >>> rtl/tcp_pkg.sv
// Purpose: constants and carriers for the timer 2 capture block
// Assumes: byte-wide register port, 250 MHz system clock
// Notes: control offset is fixed; the other offsets are local choices
package tcp_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'hc8;
   localparam logic [7:0] ADDR_CLKCTL = 8'h8e;
   localparam logic [7:0] ADDR_RLL = 8'hca;
   localparam logic [7:0] ADDR_RLH = 8'hcb;
   localparam logic [7:0] ADDR_CNTL = 8'hcc;
   localparam logic [7:0] ADDR_CNTH = 8'hcd;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'hd0;
   localparam logic [7:0] ADDR_IRQ_EN = 8'hd1;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'hd2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CLKCTL_RESET = 8'h00;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam int BIT_TFH = 7;
   localparam int BIT_TFL = 6;
   localparam int BIT_LIE = 5;
   localparam int BIT_CEN = 4;
   localparam int BIT_SPLIT = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_XCLK = 0;
   localparam int CK_LOW_SEL = 4;
   localparam int CK_HIGH_SEL = 5;
   localparam int IRQ_HIGH = 0;
   localparam int IRQ_LOW = 1;
   localparam int IRQ_CAPT = 2;
   localparam logic [3:0] DIV12_LAST = 4'hb;
   localparam logic [1:0] DIV8_LAST = 2'h3;
   localparam logic [7:0] BYTE_MAX = 8'hff;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tcp_bus_s;
endpackage

// >>> rtl/tcp_timer2.sv
// What this block does
// - count clock is system clock, system clock divided by 12, or external input
// - capture copies count into reload, sets high flag
// - capture on falling edge of oscillator over 8
// - capture on with system_clock select: count every clock
// - high flag sets when high byte wraps
// Purpose: timer 2 with external oscillator capture and overflow flags
// Assumes: one clock domain, byte register port, read data one cycle late
// Notes: irq output is high while an enabled sticky event bit is set
`timescale 1ns/100ps
module tcp_timer2 (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire tcp_pkg::tcp_bus_s i_bus,
   input wire logic i_ext_osc,
   output logic [7:0] o_rdata,
   output logic o_irq
);
   logic [7:0] ctrl_q;
   logic [7:0] clkctl_q;
   logic [7:0] cnt_lo_q;
   logic [7:0] cnt_hi_q;
   logic [7:0] rl_lo_q;
   logic [7:0] rl_hi_q;
   logic [3:0] div12_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_en_q;
   logic [7:0] rdata_q;
   logic capture;
   logic ext_tick;
   logic tick_div12;
   logic tick_lo;
   logic tick_hi;
   logic run_lo;
   logic run_hi;
   logic wrap_lo;
   logic wrap_hi;
   logic set_tfh;
   logic set_tfl;
   logic split;
   logic cen;
   localparam logic [2:0] IRQ_EN_RESET_W = tcp_pkg::IRQ_EN_RESET[2:0];

   function automatic logic wr_at(input tcp_pkg::tcp_bus_s b,
                                  input logic [7:0] a);
      wr_at = b.wr && (b.addr == a);
   endfunction

   // pick a byte clock from its system_clock select and the external select
   function automatic logic pick_tick(input logic sys_sel,
                                      input logic xclk,
                                      input logic d12,
                                      input logic ext);
      if (sys_sel) begin
         pick_tick = 1'b1;
      end else if (xclk) begin
         pick_tick = ext;
      end else begin
         pick_tick = d12;
      end
   endfunction

   tcp_edge u_edge (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_ext_osc(i_ext_osc),
      .o_fall(capture),
      .o_ext_tick(ext_tick)
   );

   assign split = ctrl_q[tcp_pkg::BIT_SPLIT];
   assign cen = ctrl_q[tcp_pkg::BIT_CEN];
   assign tick_div12 = (div12_q == tcp_pkg::DIV12_LAST);
   assign tick_lo = pick_tick(clkctl_q[tcp_pkg::CK_LOW_SEL],
      ctrl_q[tcp_pkg::BIT_XCLK], tick_div12, ext_tick);
   assign tick_hi = split ? pick_tick(clkctl_q[tcp_pkg::CK_HIGH_SEL],
      ctrl_q[tcp_pkg::BIT_XCLK], tick_div12, ext_tick) : tick_lo;
   // in split mode the low byte always runs
   assign run_lo = split | ctrl_q[tcp_pkg::BIT_RUN];
   assign run_hi = ctrl_q[tcp_pkg::BIT_RUN];
   assign wrap_lo = run_lo && tick_lo && (cnt_lo_q == tcp_pkg::BYTE_MAX);
   assign wrap_hi = split
      ? (run_hi && tick_hi && (cnt_hi_q == tcp_pkg::BYTE_MAX))
      : (wrap_lo && (cnt_hi_q == tcp_pkg::BYTE_MAX));
   assign set_tfh = wrap_hi | (cen & capture);
   assign set_tfl = wrap_lo;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         div12_q <= 4'h0;
      end else if (tick_div12) begin
         div12_q <= 4'h0;
      end else begin
         div12_q <= div12_q + 4'h1;
      end
   end

   // control and clock control; flag sets win over software writes
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_q <= tcp_pkg::CTRL_RESET;
         clkctl_q <= tcp_pkg::CLKCTL_RESET;
      end else begin
         if (wr_at(i_bus, tcp_pkg::ADDR_CTRL)) begin
            ctrl_q <= i_bus.wdata & 8'hfd;
         end
         if (wr_at(i_bus, tcp_pkg::ADDR_CLKCTL)) begin
            clkctl_q <= i_bus.wdata;
         end
         if (set_tfh) begin
            ctrl_q[tcp_pkg::BIT_TFH] <= 1'b1;
         end
         if (set_tfl) begin
            ctrl_q[tcp_pkg::BIT_TFL] <= 1'b1;
         end
      end
   end

   // count and auto-reload; capture mode keeps reload for the snapshot, except that the split-mode low byte still reloads from rl_lo_q
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_lo_q <= 8'h00;
         cnt_hi_q <= 8'h00;
      end else begin
         if (wr_at(i_bus, tcp_pkg::ADDR_CNTL)) begin
            cnt_lo_q <= i_bus.wdata;
         end else if (run_lo && tick_lo) begin
            cnt_lo_q <= (wrap_lo && split) ? rl_lo_q
               : ((wrap_hi && !cen) ? rl_lo_q : cnt_lo_q + 8'h01);
         end
         if (wr_at(i_bus, tcp_pkg::ADDR_CNTH)) begin
            cnt_hi_q <= i_bus.wdata;
         end else if (split ? (run_hi && tick_hi) : wrap_lo) begin
            cnt_hi_q <= (wrap_hi && !cen) ? rl_hi_q : cnt_hi_q + 8'h01;
         end
      end
   end

   // reload pair, loaded by software or by a capture
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rl_lo_q <= 8'h00;
         rl_hi_q <= 8'h00;
      end else if (cen && capture) begin
         rl_lo_q <= cnt_lo_q;
         rl_hi_q <= cnt_hi_q;
      end else begin
         if (wr_at(i_bus, tcp_pkg::ADDR_RLL)) begin
            rl_lo_q <= i_bus.wdata;
         end
         if (wr_at(i_bus, tcp_pkg::ADDR_RLH)) begin
            rl_hi_q <= i_bus.wdata;
         end
      end
   end

   // sticky events; a same-cycle event beats the clear
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_stat_q <= 3'h0;
         irq_en_q <= IRQ_EN_RESET_W;
      end else begin
         if (wr_at(i_bus, tcp_pkg::ADDR_IRQ_EN)) begin
            irq_en_q <= i_bus.wdata[2:0];
         end
         irq_stat_q <= (irq_stat_q
            & ~(wr_at(i_bus, tcp_pkg::ADDR_IRQ_CLR)
               ? i_bus.wdata[2:0] : 3'h0))
            | {cen & capture, set_tfl & ctrl_q[tcp_pkg::BIT_LIE], wrap_hi};
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_q <= 8'h00;
      end else if (i_bus.rd) begin
         case (i_bus.addr)
            tcp_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
            tcp_pkg::ADDR_CLKCTL: rdata_q <= clkctl_q;
            tcp_pkg::ADDR_RLL: rdata_q <= rl_lo_q;
            tcp_pkg::ADDR_RLH: rdata_q <= rl_hi_q;
            tcp_pkg::ADDR_CNTL: rdata_q <= cnt_lo_q;
            tcp_pkg::ADDR_CNTH: rdata_q <= cnt_hi_q;
            tcp_pkg::ADDR_IRQ_STAT: rdata_q <= {5'h00, irq_stat_q};
            tcp_pkg::ADDR_IRQ_EN: rdata_q <= {5'h00, irq_en_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign o_rdata = rdata_q;
   assign o_irq = |(irq_stat_q & irq_en_q);

   sequence cap_s;
      cen && capture;
   endsequence

   capture_copy_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      cap_s |=> (rl_lo_q == $past(cnt_lo_q) && rl_hi_q == $past(cnt_hi_q)))
      else $error("capture did not copy count");
   capture_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      cap_s |=> ctrl_q[tcp_pkg::BIT_TFH])
      else $error("capture did not set high flag");
   wrap_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!split && run_lo && tick_lo && cnt_lo_q == 8'hff && cnt_hi_q == 8'hff)
      |=> ctrl_q[tcp_pkg::BIT_TFH])
      else $error("high wrap missed flag");
   flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (ctrl_q[tcp_pkg::BIT_TFH] && !wr_at(i_bus, tcp_pkg::ADDR_CTRL))
      |=> ctrl_q[tcp_pkg::BIT_TFH])
      else $error("high flag dropped without a write");
   system_clock_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (clkctl_q[tcp_pkg::CK_LOW_SEL] && run_lo && !split && cnt_lo_q != 8'hff
      && !wr_at(i_bus, tcp_pkg::ADDR_CNTL))
      |=> cnt_lo_q == $past(cnt_lo_q) + 8'h01)
      else $error("count did not step each clock");
   div12_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!clkctl_q[tcp_pkg::CK_LOW_SEL] && !ctrl_q[tcp_pkg::BIT_XCLK])
      |-> (tick_lo == (div12_q == 4'hb)))
      else $error("divide by 12 tick wrong");
   read_late_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_bus.rd && i_bus.addr == tcp_pkg::ADDR_CLKCTL
      && !wr_at(i_bus, tcp_pkg::ADDR_CLKCTL))
      |=> o_rdata == $past(clkctl_q))
      else $error("read data wrong");
   irq_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (cap_s ##1 irq_en_q[tcp_pkg::IRQ_CAPT]) |-> o_irq)
      else $error("capture irq missing");
endmodule

// >>> verification/tb.sv
// Purpose: self-checking bench for the timer 2 capture block
// Assumes: reads answer one cycle after the strobe
// Notes: read expectations queue up and a monitor compares them
`timescale 1ns/100ps
module tb;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   tcp_pkg::tcp_bus_s bus = '0;
   logic osc;
   logic osc_en = 1'b0;
   logic [3:0] half = 4'h3;
   logic [7:0] o_rdata;
   logic o_irq;
   logic rd_q = 1'b0;
   int num_errors = 0;
   int tests_run = 0;
   int seed = 47;
   typedef struct {logic [7:0] e; logic [7:0] m;} tcp_note_s;
   tcp_note_s notes[$];
   logic [15:0] v1, v2;
   logic [7:0] d;

   always #2 i_clk = ~i_clk;

   tcp_timer2 tcp_timer2_i (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_bus(bus), .i_ext_osc(osc), .o_rdata(o_rdata), .o_irq(o_irq));
   tcp_osc_model tcp_osc_model_i (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_en(osc_en), .i_half(half), .o_osc(osc));

   task automatic check(input string n, input logic [15:0] s,
                        input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input logic [7:0] m);
      @(posedge i_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      notes.push_back('{e, m});
      @(posedge i_clk);
      bus.rd <= 1'b0;
      @(posedge i_clk);
      d = o_rdata;
   endtask

   task automatic rd_rl(output logic [15:0] v);
      rd(tcp_pkg::ADDR_RLL, 8'h00, 8'h00);
      v[7:0] = d;
      rd(tcp_pkg::ADDR_RLH, 8'h00, 8'h00);
      v[15:8] = d;
   endtask

   task automatic wait_irq();
      for (int i = 0; i < 1000 && o_irq !== 1'b1; i++) @(posedge i_clk);
      check("irq_wait", {15'h0, o_irq}, 16'h1);
   endtask

   always @(posedge i_clk) begin
      if (rd_q && notes.size() > 0) begin
         if (notes[0].m != 8'h00)
            check("rdata", {8'h00, o_rdata & notes[0].m},
                  {8'h00, notes[0].e & notes[0].m});
         void'(notes.pop_front());
      end
      rd_q <= bus.rd;
   end

   // whole run needs about 1000 cycles
   initial begin
      #200000;
      num_errors++;
      end_sim();
   end

   initial begin
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(tcp_pkg::ADDR_CTRL, tcp_pkg::CTRL_RESET, 8'hff);
      rd(tcp_pkg::ADDR_CLKCTL, tcp_pkg::CLKCTL_RESET, 8'hff);
      rd(tcp_pkg::ADDR_IRQ_EN, tcp_pkg::IRQ_EN_RESET, 8'hff);
      rd(8'h10, 8'h00, 8'hff);
      check("irq_reset", {15'h0, o_irq}, 16'h0);
      $display("test reset done");
      // system_clock, system_clock over 12, external input of period 6; 120 apart
      for (int i = 0; i < 3; i++) begin
         osc_en <= (i == 2);
         wr(tcp_pkg::ADDR_CLKCTL, i == 0 ? 8'h10 : 8'h00);
         wr(tcp_pkg::ADDR_CTRL, i == 2 ? 8'h05 : 8'h04);
         rd(tcp_pkg::ADDR_CNTL, 8'h00, 8'h00);
         v1[7:0] = d;
         repeat (117) @(posedge i_clk);
         rd(tcp_pkg::ADDR_CNTL, 8'h00, 8'h00);
         check("count_step", {8'h00, d - v1[7:0]},
               i == 0 ? 16'd120 : i == 1 ? 16'd10 : 16'd20);
      end
      osc_en <= 1'b0;
      $display("test count clock done");
      for (int i = 0; i < 2; i++) begin
         half <= 4'd3 + 4'(6 * i) + 4'($unsigned($random(seed)) % 3);
         wr(tcp_pkg::ADDR_CTRL, 8'h00);
         wr(tcp_pkg::ADDR_CLKCTL, 8'h10);
         wr(tcp_pkg::ADDR_CTRL, 8'h14);
         wr(tcp_pkg::ADDR_IRQ_EN, 8'h04);
         wr(tcp_pkg::ADDR_IRQ_CLR, 8'h07);
         osc_en <= 1'b1;
         wait_irq();
         rd(tcp_pkg::ADDR_CTRL, 8'h80, 8'h80);
         wr(tcp_pkg::ADDR_IRQ_CLR, 8'h04);
         rd_rl(v1);
         wait_irq();
         wr(tcp_pkg::ADDR_IRQ_CLR, 8'h04);
         rd_rl(v2);
         check("capture_gap", v2 - v1, {8'h00, half, 4'h0});
         // first write stops the timer, so no flag can set after the second
         wr(tcp_pkg::ADDR_CTRL, 8'h00);
         wr(tcp_pkg::ADDR_CTRL, 8'h00);
         rd(tcp_pkg::ADDR_CTRL, 8'h00, 8'hff);
         osc_en <= 1'b0;
      end
      $display("test capture done");
      wr(tcp_pkg::ADDR_CTRL, 8'h04);
      wr(tcp_pkg::ADDR_IRQ_EN, 8'h01);
      wr(tcp_pkg::ADDR_IRQ_CLR, 8'h07);
      // low byte first so it cannot wrap before the high byte lands
      wr(tcp_pkg::ADDR_CNTL, 8'hf0);
      wr(tcp_pkg::ADDR_CNTH, 8'hff);
      rd(tcp_pkg::ADDR_CTRL, 8'h00, 8'h80);
      wait_irq();
      rd(tcp_pkg::ADDR_CTRL, 8'h80, 8'h80);
      wr(tcp_pkg::ADDR_IRQ_EN, 8'h00);
      @(posedge i_clk);
      check("irq_masked", {15'h0, o_irq}, 16'h0);
      wr(tcp_pkg::ADDR_IRQ_STAT, 8'h00);
      rd(tcp_pkg::ADDR_IRQ_STAT, 8'h01, 8'h01);
      wr(tcp_pkg::ADDR_IRQ_CLR, 8'h01);
      rd(tcp_pkg::ADDR_IRQ_STAT, 8'h00, 8'h05);
      rd(tcp_pkg::ADDR_CTRL, 8'h80, 8'h80);
      wr(tcp_pkg::ADDR_IRQ_EN, 8'h01);
      @(posedge i_clk);
      check("irq_cleared", {15'h0, o_irq}, 16'h0);
      $display("test overflow done");
      end_sim();
   end
endmodule

// >>> verification/tcp_osc_model.sv
// Purpose: free-running external oscillator that the capture block measures
// Assumes: half period given in i_clk cycles, at least 1
// Notes: sits low while disabled
`timescale 1ns/100ps
module tcp_osc_model (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_en,
   input wire logic [3:0] i_half,
   output logic o_osc
);
   logic [3:0] cnt_q;
   // long levels keep the capture clock far below the count clock
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q <= 4'h0;
         o_osc <= 1'b0;
      end else if (!i_en) begin
         cnt_q <= 4'h0;
         o_osc <= 1'b0;
      end else if (cnt_q >= i_half - 4'h1) begin
         cnt_q <= 4'h0;
         o_osc <= ~o_osc;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule
